// >>> core/ssa_core.sv
// module: strobed and polled status record assembly for the scanner virtual node
// Functional notes
// - scanner shows as virtual node with strobed and polled status connections
// - strobed record is fixed at 24 bytes, polled at 64 bytes
// - records go to controller every controller scan, or every n scans
// - strobed bytes 0 and 1 hold last network scan processing time
// - bytes 2 to 9 hold membership bits, node 0 in bit 0
// - membership bit set only when node is active and mapped
// - bytes 10 to 17 hold connection error bits, same ordering
// - error bit reads 0 for any node not in the scan list
// - error bits carry only communication faults, not node reported faults
// - byte 18 carries scanner own status code
// - byte 19 carries scanner error code, as pseudo node 91
// - byte 20 carries bus controller hardware status code, as pseudo node 96
// - byte 21 carries network access status code, as pseudo node 97
// - bytes 22 and 23 hold 16 bit pass counter, wrapping at 65535
// - polled record supplies a status code for every node
// - polled status code of a node sits at byte equal to its address
// - polled code reads 24 hex while node communication is normal
module ssa_core
  import ssa_pkg::*;
(
  // clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  // scan engine report
  input  wire ssa_scan_s              scan_i,
  input  wire logic [NODES*8-1:0]     node_code_i,
  input  wire logic [IDX_W-1:0]       scanner_addr_i,
  // controller side
  input  wire logic                   ctl_scan_i,
  input  wire logic [7:0]             rate_i,
  input  wire ssa_rd_s                rd_i,
  output logic      [7:0]             rd_data_o,
  output logic                        rd_valid_o,
  output logic                        publish_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssa_stb_s           stg_stb;
    logic [NODES*8-1:0] stg_pol;
    ssa_stb_s           pub_stb;
    logic [NODES*8-1:0] pub_pol;
    logic [15:0]        pass_cnt;
    logic [7:0]         rate_cnt;
    logic [7:0]         rd_data;
    logic               rd_valid;
    logic               publish;
  } ssa_state_s;

  ssa_state_s state_ff;
  ssa_state_s nxt_state;

  // ----------------------------------------------------------------
  // byte pick, shared by both record reads
  // ----------------------------------------------------------------
  function automatic logic [7:0] ssa_pick(input logic [NODES*8-1:0] rec,
                                          input logic [IDX_W-1:0]   idx,
                                          input int                 len);
    logic [7:0] b;
    b = 8'h00;
    if (int'(idx) < len) begin
      b = rec[idx*8 +: 8];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // per node membership and polled code
  // ----------------------------------------------------------------
  logic [NODES-1:0]   member;
  logic [NODES*8-1:0] pol_codes;

  for (genvar n = 0; n < NODES; n++) begin : g_node
    // only comm faults enter here; node-reported faults stay in its own io data
    assign member[n] = scan_i.active[n] & scan_i.mapped[n];
    always_comb begin
      if (n == int'(scanner_addr_i)) begin
        pol_codes[n*8 +: 8] = scan_i.state_code;
      end else if (member[n] && !scan_i.conn_fault[n]) begin
        pol_codes[n*8 +: 8] = NODE_OK_CODE;
      end else begin
        pol_codes[n*8 +: 8] = node_code_i[n*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       pub_now;
  logic [7:0] rate_eff;

  always_comb begin
    nxt_state = state_ff;
    rate_eff  = (rate_i == RATE_RST) ? RATE_DEFAULT : rate_i;
    pub_now   = 1'b0;
    nxt_state.publish  = 1'b0;
    nxt_state.rd_valid = 1'b0;

    // staging snapshot at each scan boundary, all fields in one cycle
    if (scan_i.done) begin
      nxt_state.pass_cnt                           = state_ff.pass_cnt + 16'h0001;
      nxt_state.stg_stb.network_pass_counter       = state_ff.pass_cnt + 16'h0001;
      nxt_state.stg_stb.io_processing_time         = scan_i.proc_time;
      nxt_state.stg_stb.scan_membership_flags      = member;
      nxt_state.stg_stb.node_error_flags           = member & scan_i.conn_fault;
      nxt_state.stg_stb.scanner_state_code         = scan_i.state_code;
      nxt_state.stg_stb.scanner_fault_code         = scan_i.fault_code;
      nxt_state.stg_stb.bus_hw_state_code          = scan_i.bus_hw_code;
      nxt_state.stg_stb.net_access_state_code      = scan_i.net_access_code;
      nxt_state.stg_pol                            = pol_codes;
    end

    // hand-over to controller view every rate_eff controller scans
    if (ctl_scan_i) begin
      if (state_ff.rate_cnt + 8'h01 >= rate_eff) begin
        pub_now            = 1'b1;
        nxt_state.rate_cnt = 8'h00;
      end else begin
        nxt_state.rate_cnt = state_ff.rate_cnt + 8'h01;
      end
    end
    if (pub_now) begin
      // takes the last complete staging, never one being written this cycle
      nxt_state.pub_stb = state_ff.stg_stb;
      nxt_state.pub_pol = state_ff.stg_pol;
      nxt_state.publish = 1'b1;
    end

    // controller read, one cycle latency
    if (rd_i.req) begin
      nxt_state.rd_valid = 1'b1;
      if (rd_i.polled) begin
        nxt_state.rd_data = ssa_pick(state_ff.pub_pol, rd_i.idx, POL_BYTES);
      end else begin
        nxt_state.rd_data = ssa_pick({{(NODES*8-$bits(ssa_stb_s)){1'b0}}, state_ff.pub_stb},
                                     rd_i.idx, STB_BYTES);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_ff          <= '0;
      state_ff.pass_cnt <= PASS_CNT_RST;
      state_ff.rate_cnt <= RATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data_o  = state_ff.rd_data;
  assign rd_valid_o = state_ff.rd_valid;
  assign publish_o  = state_ff.publish;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  AST_RD_LATENCY: assert property (rd_i.req |=> rd_valid_o)
    else $error("read answer missing one cycle after request");

  AST_RD_NO_SPUR: assert property (!rd_i.req |=> !rd_valid_o)
    else $error("read answer without request");

  AST_STB_LEN: assert property (rd_i.req && !rd_i.polled && int'(rd_i.idx) >= STB_BYTES |=> rd_data_o == 8'h00)
    else $error("strobed byte beyond record is not zero");

  AST_PTIME: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_IO_PROCESSING_TIME
                              |=> rd_data_o == $past(state_ff.pub_stb.io_processing_time[7:0]))
    else $error("processing time low byte wrong");

  AST_MEMBER: assert property (scan_i.done |=> state_ff.stg_stb.scan_membership_flags
                               == $past(scan_i.active & scan_i.mapped))
    else $error("membership flags not active and mapped");

  AST_ERR_MASK: assert property ((state_ff.stg_stb.node_error_flags
                                 & ~state_ff.stg_stb.scan_membership_flags) == '0)
    else $error("error flag set on node outside scan list");

  AST_ERR_SET: assert property (scan_i.done |=> state_ff.stg_stb.node_error_flags
                                == $past(member & scan_i.conn_fault))
    else $error("error flags do not follow connection faults");

  AST_CODES: assert property (scan_i.done |=> state_ff.stg_stb.scanner_fault_code == $past(scan_i.fault_code)
                              && state_ff.stg_stb.bus_hw_state_code == $past(scan_i.bus_hw_code)
                              && state_ff.stg_stb.net_access_state_code == $past(scan_i.net_access_code))
    else $error("scanner codes not captured");

  AST_PASS_INC: assert property (scan_i.done
                                 |=> state_ff.pass_cnt == 16'($past(state_ff.pass_cnt) + 16'h0001))
    else $error("pass counter did not step by one");

  AST_PASS_HOLD: assert property (!scan_i.done |=> $stable(state_ff.pass_cnt))
    else $error("pass counter moved without scan");

  AST_EVERY_SCAN: assert property (ctl_scan_i && rate_i <= 8'h01 |=> publish_o)
    else $error("records not published on controller scan");

  AST_PUB_COPY: assert property (publish_o |-> state_ff.pub_stb == $past(state_ff.stg_stb))
    else $error("published record differs from staging");

  AST_OK_CODE: assert property (scan_i.done && member[1] && !scan_i.conn_fault[1] && scanner_addr_i != 6'h01
                                |=> state_ff.stg_pol[15:8] == NODE_OK_CODE)
    else $error("normal node code not 24 hex");

  // ----------------------------------------------------------------
  // assertions: staging capture
  // ----------------------------------------------------------------
  AST_STATE_CAP: assert property (scan_i.done
                                  |=> state_ff.stg_stb.scanner_state_code == $past(scan_i.state_code))
    else $error("scanner state code not captured");

  AST_BUS_CAP: assert property (scan_i.done
                                |=> state_ff.stg_stb.bus_hw_state_code == $past(scan_i.bus_hw_code))
    else $error("bus hardware code not captured");

  AST_NET_CAP: assert property (scan_i.done
                                |=> state_ff.stg_stb.net_access_state_code == $past(scan_i.net_access_code))
    else $error("network access code not captured");

  AST_PTIME_CAP: assert property (scan_i.done
                                  |=> state_ff.stg_stb.io_processing_time == $past(scan_i.proc_time))
    else $error("processing time not captured");

  AST_PASS_STG: assert property (scan_i.done
                                 |=> state_ff.stg_stb.network_pass_counter == state_ff.pass_cnt)
    else $error("staged pass counter differs from running count");

  AST_SELF_CODE: assert property (scan_i.done
                                  |=> state_ff.stg_pol[$past(scanner_addr_i)*8 +: 8] == $past(scan_i.state_code))
    else $error("scanner own polled code wrong");

  AST_STG_HOLD: assert property (!scan_i.done
                                 |=> $stable(state_ff.stg_stb))
    else $error("staging moved without scan end");

  // ----------------------------------------------------------------
  // assertions: publish and read back
  // ----------------------------------------------------------------
  AST_PUB_HOLD: assert property (!publish_o
                                 |-> $stable(state_ff.pub_stb))
    else $error("published record moved without publish");

  AST_NO_PUB: assert property (!ctl_scan_i
                               |=> !publish_o)
    else $error("publish without controller scan");

  AST_PUB_MASK: assert property ((state_ff.pub_stb.node_error_flags
                                 & ~state_ff.pub_stb.scan_membership_flags) == '0)
    else $error("published error flag outside scan list");

  AST_RD_HOLD: assert property (!rd_i.req
                                |=> $stable(rd_data_o))
    else $error("read data moved without request");

  AST_PTIME_HI: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_IO_PROCESSING_TIME + 6'h01
                                 |=> rd_data_o == $past(state_ff.pub_stb.io_processing_time[15:8]))
    else $error("processing time high byte wrong");

  AST_MEMBER_LO: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_SCAN_MEMBERSHIP_FLAGS
                                  |=> rd_data_o == $past(state_ff.pub_stb.scan_membership_flags[7:0]))
    else $error("membership byte for nodes 0 to 7 wrong");

  AST_MEMBER_HI: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_SCAN_MEMBERSHIP_FLAGS + 6'h07
                                  |=> rd_data_o == $past(state_ff.pub_stb.scan_membership_flags[63:56]))
    else $error("membership byte for nodes 56 to 63 wrong");

  AST_ERR_LO: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_NODE_ERROR_FLAGS
                               |=> rd_data_o == $past(state_ff.pub_stb.node_error_flags[7:0]))
    else $error("error byte for nodes 0 to 7 wrong");

  AST_ERR_HI: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_NODE_ERROR_FLAGS + 6'h07
                               |=> rd_data_o == $past(state_ff.pub_stb.node_error_flags[63:56]))
    else $error("error byte for nodes 56 to 63 wrong");

  AST_STATE_RD: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_SCANNER_STATE_CODE
                                 |=> rd_data_o == $past(state_ff.pub_stb.scanner_state_code))
    else $error("scanner state byte wrong");

  AST_FAULT_RD: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_SCANNER_FAULT_CODE
                                 |=> rd_data_o == $past(state_ff.pub_stb.scanner_fault_code))
    else $error("scanner fault byte wrong");

  AST_BUS_RD: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_BUS_HW_STATE_CODE
                               |=> rd_data_o == $past(state_ff.pub_stb.bus_hw_state_code))
    else $error("bus hardware byte wrong");

  AST_NET_RD: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_NET_ACCESS_STATE_CODE
                               |=> rd_data_o == $past(state_ff.pub_stb.net_access_state_code))
    else $error("network access byte wrong");

  AST_PASS_LO: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_NETWORK_PASS_COUNTER
                                |=> rd_data_o == $past(state_ff.pub_stb.network_pass_counter[7:0]))
    else $error("pass counter low byte wrong");

  AST_PASS_HI: assert property (rd_i.req && !rd_i.polled && rd_i.idx == OFS_NETWORK_PASS_COUNTER + 6'h01
                                |=> rd_data_o == $past(state_ff.pub_stb.network_pass_counter[15:8]))
    else $error("pass counter high byte wrong");

  AST_POL_RD: assert property (rd_i.req && rd_i.polled
                               |=> rd_data_o == $past(state_ff.pub_pol[rd_i.idx*8 +: 8]))
    else $error("polled byte not at node address");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  COV_PUBLISH: cover property (ctl_scan_i ##1 publish_o);
  COV_WRAP:    cover property (scan_i.done && state_ff.pass_cnt == 16'hffff);
  COV_POL_RD:  cover property (rd_i.req && rd_i.polled ##1 rd_valid_o);
  COV_SLOW:    cover property (ctl_scan_i && rate_i > 8'h01 ##1 !publish_o);
  COV_RATE0:   cover property (ctl_scan_i && rate_i == 8'h00 ##1 publish_o);

endmodule

// >>> core/ssa_pkg.sv
// package: record layouts and constants for the scanner status assembly
package ssa_pkg;

  // ----------------------------------------------------------------
  // record sizes and node count
  // ----------------------------------------------------------------
  localparam int NODES        = 64;
  localparam int STB_BYTES    = 24;
  localparam int POL_BYTES    = 64;
  localparam int IDX_W        = 6;

  // ----------------------------------------------------------------
  // strobed record byte offsets
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] OFS_IO_PROCESSING_TIME    = 6'h00;
  localparam logic [IDX_W-1:0] OFS_SCAN_MEMBERSHIP_FLAGS = 6'h02;
  localparam logic [IDX_W-1:0] OFS_NODE_ERROR_FLAGS      = 6'h0a;
  localparam logic [IDX_W-1:0] OFS_SCANNER_STATE_CODE    = 6'h12;
  localparam logic [IDX_W-1:0] OFS_SCANNER_FAULT_CODE    = 6'h13;
  localparam logic [IDX_W-1:0] OFS_BUS_HW_STATE_CODE     = 6'h14;
  localparam logic [IDX_W-1:0] OFS_NET_ACCESS_STATE_CODE = 6'h15;
  localparam logic [IDX_W-1:0] OFS_NETWORK_PASS_COUNTER  = 6'h16;

  // ----------------------------------------------------------------
  // codes, reset values and rate
  // ----------------------------------------------------------------
  localparam logic [7:0]  NODE_OK_CODE   = 8'h24;
  localparam logic [15:0] PASS_CNT_RST   = 16'h0000;
  localparam logic [7:0]  RATE_RST       = 8'h00;
  localparam logic [7:0]  RATE_DEFAULT   = 8'h01;

  // ----------------------------------------------------------------
  // strobed record, byte 0 in the low bits
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      network_pass_counter;
    logic [7:0]       net_access_state_code;
    logic [7:0]       bus_hw_state_code;
    logic [7:0]       scanner_fault_code;
    logic [7:0]       scanner_state_code;
    logic [NODES-1:0] node_error_flags;
    logic [NODES-1:0] scan_membership_flags;
    logic [15:0]      io_processing_time;
  } ssa_stb_s;

  // ----------------------------------------------------------------
  // end-of-scan report from the scan engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             done;
    logic [15:0]      proc_time;
    logic [NODES-1:0] active;
    logic [NODES-1:0] mapped;
    logic [NODES-1:0] conn_fault;
    logic [7:0]       state_code;
    logic [7:0]       fault_code;
    logic [7:0]       bus_hw_code;
    logic [7:0]       net_access_code;
  } ssa_scan_s;

  // ----------------------------------------------------------------
  // controller read request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             req;
    logic             polled;
    logic [IDX_W-1:0] idx;
  } ssa_rd_s;

endpackage

// >>> verification/ssa_ctl_model.sv
// controller model: issues controller scans and reads mapped status bytes
module ssa_ctl_model
  import ssa_pkg::*;
(
  // clock
  input  wire logic       clock_i,
  // controller side of the status block
  output logic            ctl_scan_o,
  output ssa_rd_s         rd_o,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  input  wire logic       publish_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    ctl_scan_o = 1'b0;
    rd_o       = '0;
  end

  // ----------------------------------------------------------------
  // controller scan and byte read
  // ----------------------------------------------------------------
  task automatic ctl_pulse(output logic pub);
    @(posedge clock_i);
    ctl_scan_o <= 1'b1;
    @(posedge clock_i);
    ctl_scan_o <= 1'b0;
    #1;
    pub = publish_i;
  endtask

  // request held for exactly the edge that takes it
  task automatic read_byte(input logic p, input logic [IDX_W-1:0] i, output logic [7:0] d, output logic v);
    @(posedge clock_i);
    rd_o <= '{1'b1, p, i};
    @(posedge clock_i);
    rd_o.req <= 1'b0;
    #1;
    v = rd_valid_i;
    d = rd_data_i;
  endtask

  // inputs of an offline node are not trusted by the controller
  function automatic logic node_usable(input logic [7:0] code);
    return code === NODE_OK_CODE;
  endfunction
endmodule

// >>> verification/testbench.sv
// testbench: random and corner-case checks of the status record assembly
module testbench
  import ssa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clock_i, nrst_i, ctl_scan, rd_valid, publish;
  ssa_scan_s            scan, stg, pub;
  ssa_rd_s              rd;
  logic [NODES*8-1:0]   node_code, stg_nc, pub_nc;
  logic [IDX_W-1:0]     saddr;
  logic [7:0]           rate, rd_data;
  logic [15:0]          stg_cnt, pub_cnt;
  int                   err_count, compares, cyc, seed;

  // ----------------------------------------------------------------
  // design and controller model
  // ----------------------------------------------------------------
  ssa_core u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .scan_i(scan), .node_code_i(node_code),
    .scanner_addr_i(saddr), .ctl_scan_i(ctl_scan), .rate_i(rate), .rd_i(rd), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .publish_o(publish));
  ssa_ctl_model u_ctl (.clock_i(clock_i), .ctl_scan_o(ctl_scan), .rd_o(rd), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .publish_i(publish));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // expectation and checking
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_byte(input logic p, input logic [IDX_W-1:0] i);
    logic [NODES-1:0] m;
    ssa_stb_s         r;
    m = pub.active & pub.mapped;
    if (p) begin
      if (i == saddr) return pub.state_code;
      if (m[i] & ~pub.conn_fault[i]) return NODE_OK_CODE;
      return pub_nc[i*8+:8];
    end
    r = '{pub_cnt, pub.net_access_code, pub.bus_hw_code, pub.fault_code, pub.state_code,
          m & pub.conn_fault, m, pub.proc_time};
    if (i >= STB_BYTES) return 8'h00;
    return r[i*8+:8];
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("errors %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // done held n cycles gives n back-to-back scan ends
  task automatic scan_done(input int n);
    ssa_scan_s          s;
    logic [NODES*8-1:0] nc;
    s.done = 1'b1;
    s.proc_time = $random(seed);
    s.active = {$random(seed), $random(seed)};
    s.mapped = {$random(seed), $random(seed)};
    s.conn_fault = {$random(seed), $random(seed)};
    {s.state_code, s.fault_code, s.bus_hw_code, s.net_access_code} = $random(seed);
    for (int b = 0; b < NODES; b++) nc[b*8+:8] = $random(seed);
    @(posedge clock_i);
    scan <= s;
    node_code <= nc;
    repeat (n) @(posedge clock_i);
    scan.done <= 1'b0;
    stg = s;
    stg_nc = nc;
    stg_cnt = stg_cnt + n[15:0];
  endtask

  task automatic publish_chk(input logic exp);
    logic seen;
    u_ctl.ctl_pulse(seen);
    chk("publish", seen, exp);
    if (exp) begin
      pub = stg;
      pub_nc = stg_nc;
      pub_cnt = stg_cnt;
    end
  endtask

  task automatic read_chk(input logic p, input logic [IDX_W-1:0] i);
    logic [7:0] d;
    logic       v;
    u_ctl.read_byte(p, i, d, v);
    chk("rd_valid", v, 1'b1);
    if (p) chk("node usable", u_ctl.node_usable(d), exp_byte(p, i) == NODE_OK_CODE);
    chk("record byte", {1'b0, p, i, d}, {1'b0, p, i, exp_byte(p, i)});
  endtask

  task automatic check_all();
    for (int i = 0; i < 64; i++) begin
      read_chk(1'b0, i[IDX_W-1:0]);
      read_chk(1'b1, i[IDX_W-1:0]);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      results();
    end
  end

  initial begin
    logic [7:0] rates [3];
    int         eff;
    rates = '{8'h00, 8'h03, 8'hff};
    seed = 89;
    err_count = 0;
    compares = 0;
    cyc = 0;
    nrst_i = 1'b0;
    scan = '0;
    node_code = '0;
    saddr = $random(seed);
    rate = 8'h01;
    stg = '0;
    pub = '0;
    stg_nc = '0;
    pub_nc = '0;
    stg_cnt = PASS_CNT_RST;
    pub_cnt = PASS_CNT_RST;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    publish_chk(1'b1);
    check_all();
    for (int k = 0; k < 3; k++) begin
      scan_done(k == 0 ? 2 : 1);
      read_chk(1'b0, OFS_NETWORK_PASS_COUNTER);
      publish_chk(1'b1);
      check_all();
    end
    // zero rate means every scan, as rate 1 does; rates above 1 skip scans
    foreach (rates[r]) begin
      @(posedge clock_i);
      rate <= rates[r];
      eff = (rates[r] == 8'h00) ? 1 : rates[r];
      for (int j = 0; j < eff; j++) publish_chk(j == eff - 1);
    end
    @(posedge clock_i);
    rate <= 8'h01;
    scan_done(65537 - stg_cnt);
    publish_chk(1'b1);
    check_all();
    results();
  end
endmodule
